/* fast_serial_pkg.sv */
// constants, types and helpers shared by the fast serial port
package fast_serial_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  // register offsets
  localparam logic [11:0] OFS_MODE = 12'hc00;
  localparam logic [11:0] OFS_CTRL = 12'hc02;
  localparam logic [11:0] OFS_STAT = 12'hc04;
  localparam logic [11:0] OFS_CRC = 12'hc06;
  localparam logic [11:0] OFS_IS = 12'hc08;
  localparam logic [11:0] OFS_WE = 12'hc0a;
  localparam logic [11:0] OFS_IE = 12'hc0c;
  localparam logic [11:0] OFS_IR = 12'hc0e;
  localparam logic [11:0] OFS_TXWB = 12'hc10;
  localparam logic [11:0] OFS_RXRB = 12'hc12;
  localparam logic [11:0] OFS_TXSB = 12'hc14;
  localparam logic [11:0] OFS_RXSB = 12'hc16;
  // mode_setting fields
  localparam int MD_LOOP = 15;
  localparam int MD_ORDER = 14;
  localparam int MD_IDLE = 13;
  localparam int MD_TXE = 11;
  localparam int MD_RXE = 10;
  localparam int MD_TINV = 9;
  localparam int MD_RINV = 8;
  localparam int MD_CKEN = 6;
  localparam int MD_DIV_HI = 2;
  localparam int MD_DIV_LO = 0;
  // transfer_control fields
  localparam int CT_POLY = 15;
  localparam int CT_SRC = 14;
  localparam int CT_CLRN = 13;
  localparam int CT_DMAW = 9;
  localparam int CT_DMAR = 8;
  localparam int CT_UNIT = 5;
  localparam int CT_ALGN = 2;
  localparam int CT_SEQ = 1;
  localparam int CT_ONE = 0;
  // reset values and writable masks
  localparam logic [15:0] MODE_RST = 16'h6000;
  localparam logic [15:0] CTRL_RST = 16'h0040;
  localparam logic [15:0] MODE_WMASK = 16'hef47;
  localparam logic [15:0] CTRL_WMASK = 16'he367;
  localparam logic [15:0] IRQ_WMASK = 16'h000f;
  // condition order: tx shift empty, rx shift full, tx buf empty, rx buf full
  localparam logic [3:0] COND_RST = 4'ha;
  localparam logic [5:0] TICK_LAST8 = 6'h0f;
  localparam logic [5:0] TICK_LAST16 = 6'h1f;
  localparam logic [6:0] CRC7_POLY = 7'h09;
  localparam logic [15:0] CRC16_POLY = 16'h1021;

  typedef enum logic {ST_IDLE, ST_RUN} xfer_state_t;

  // cycles per half shift clock, minus one
  function automatic logic [4:0] half_cnt(input logic [2:0] sel);
    logic [4:0] h;
    h = 5'h1f;
    case (sel)
      3'h1: h = 5'h00;
      3'h2: h = 5'h01;
      3'h3: h = 5'h03;
      3'h4: h = 5'h07;
      3'h5: h = 5'h0f;
      default: h = 5'h1f;
    endcase
    return h;
  endfunction

  // word position of the k-th bit on the wire
  function automatic logic [3:0] bit_pos(input logic [4:0] k, input logic msb,
                                         input logic u16);
    logic [3:0] top;
    top = u16 ? 4'hf : 4'h7;
    return msb ? 4'(top - k[3:0]) : k[3:0];
  endfunction
endpackage

/* stream_if.sv */
// valid/ready word stream between internal modules
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 16) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* stream_fifo.sv */
// first-in first-out word buffer, depth a power of two
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_s.ready = cnt_r != FULL_CNT;
  assign out_s.valid = cnt_r != '0;
  assign out_s.data = mem[rp_r];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* crc_engine.sv */
// bit-serial crc-7 / crc-16 generator
`timescale 1ns/1ps
`default_nettype none
module crc_engine
  import fast_serial_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear_n,
  input wire logic poly16,
  input wire logic bit_vld,
  input wire logic bit_in,
  output logic [15:0] crc
);
  logic [15:0] crc_r;
  logic fb7;
  logic fb16;
  logic [6:0] c7;
  logic [15:0] c16;

  assign fb7 = bit_in ^ crc_r[6];
  assign c7 = {crc_r[5:0], 1'b0} ^ (fb7 ? CRC7_POLY : 7'h00);
  assign fb16 = bit_in ^ crc_r[15];
  assign c16 = {crc_r[14:0], 1'b0} ^ (fb16 ? CRC16_POLY : 16'h0000);
  assign crc = crc_r;

  always_ff @(posedge clk) begin
    if (!rst_n || !clear_n) begin
      crc_r <= 16'h0000;
    end else if (bit_vld) begin
      crc_r <= poly16 ? c16 : {9'h000, c7};
    end
  end
endmodule
`default_nettype wire

/* fast_serial_port.sv */
// master-only synchronous serial port with crc and buffered transmit
`timescale 1ns/1ps
`default_nettype none
module fast_serial_port
  import fast_serial_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic tx_space,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin,
  output logic serial_clock_pin,
  output logic combined_port_irq,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] mode_r;
  logic [15:0] ctrl_r;
  logic [15:0] we_r;
  logic [15:0] ie_r;
  logic [15:0] txsh_r;
  logic [15:0] rxsh_r;
  logic [15:0] rdbuf_r;
  logic [15:0] rdata_r;
  logic [3:0] is_r;
  logic [3:0] cond_d_r;
  logic tx_full_r;
  logic rend_r;
  logic rfr_r;
  logic unit_pend_r;
  logic sclk_r;
  logic sdo_r;
  logic sampled_r;
  logic xtx_r;
  logic xrx_r;
  logic irq_r;
  logic dmat_r;
  logic dmar_r;
  logic space_r;
  logic [4:0] div_cnt_r;
  logic [4:0] bit_tx_r;
  logic [4:0] bit_rx_r;
  logic [5:0] tick_cnt_r;
  xfer_state_t state_r;

  stream_if #(.W(DATA_W)) wr_s ();
  stream_if #(.W(DATA_W)) rd_s ();

  stream_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_s(wr_s),
    .out_s(rd_s)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_md;
  logic hit_ct;
  logic hit_st;
  logic hit_cr;
  logic hit_is;
  logic hit_we;
  logic hit_ie;
  logic hit_ir;
  logic hit_td;
  logic hit_rd;
  logic hit_ts;
  logic hit_rs;
  assign hit_md = bus_addr == OFS_MODE;
  assign hit_ct = bus_addr == OFS_CTRL;
  assign hit_st = bus_addr == OFS_STAT;
  assign hit_cr = bus_addr == OFS_CRC;
  assign hit_is = bus_addr == OFS_IS;
  assign hit_we = bus_addr == OFS_WE;
  assign hit_ie = bus_addr == OFS_IE;
  assign hit_ir = bus_addr == OFS_IR;
  assign hit_td = bus_addr == OFS_TXWB;
  assign hit_rd = bus_addr == OFS_RXRB;
  assign hit_ts = bus_addr == OFS_TXSB;
  assign hit_rs = bus_addr == OFS_RXSB;

  // ----------------------------------------------------------------
  // setting fields
  // ----------------------------------------------------------------
  logic loop_en;
  logic msb_first;
  logic idle_lvl;
  logic tx_rise;
  logic rx_rise;
  logic tx_inv;
  logic rx_inv;
  logic clk_en;
  logic [2:0] div_sel;
  logic crc16;
  logic crc_rx;
  logic crc_run;
  logic dmaw_en;
  logic dmar_en;
  logic u16;
  logic align;
  logic seq_rx;
  logic unit_rx;
  assign loop_en = mode_r[MD_LOOP];
  assign msb_first = mode_r[MD_ORDER];
  assign idle_lvl = mode_r[MD_IDLE];
  assign tx_rise = mode_r[MD_TXE];
  assign rx_rise = mode_r[MD_RXE];
  assign tx_inv = mode_r[MD_TINV];
  assign rx_inv = mode_r[MD_RINV];
  assign clk_en = mode_r[MD_CKEN];
  assign div_sel = mode_r[MD_DIV_HI:MD_DIV_LO];
  assign crc16 = ctrl_r[CT_POLY];
  assign crc_rx = ctrl_r[CT_SRC];
  assign crc_run = ctrl_r[CT_CLRN];
  assign dmaw_en = ctrl_r[CT_DMAW];
  assign dmar_en = ctrl_r[CT_DMAR];
  assign u16 = ctrl_r[CT_UNIT];
  assign align = ctrl_r[CT_ALGN];
  assign seq_rx = ctrl_r[CT_SEQ];
  assign unit_rx = ctrl_r[CT_ONE] & !seq_rx;

  // ----------------------------------------------------------------
  // shift clock timing
  // ----------------------------------------------------------------
  logic div_ok;
  logic tick;
  logic running;
  logic toggle;
  logic live;
  logic rise;
  logic fall;
  logic launch;
  logic sample;
  logic done;
  logic advance;
  assign div_ok = div_sel != 3'h0;
  assign tick = clk_en & div_ok & (div_cnt_r == half_cnt(div_sel));
  assign running = state_r == ST_RUN;
  assign toggle = tick & (running | loop_en);
  // a transfer starts counting only from a low clock
  assign live = running & tick & ((tick_cnt_r != 6'h00) | !sclk_r);
  assign rise = live & !sclk_r;
  assign fall = live & sclk_r;
  assign launch = tx_rise ? rise : fall;
  assign sample = rx_rise ? rise : fall;
  assign done = live & (tick_cnt_r == (u16 ? TICK_LAST16 : TICK_LAST8));
  // never move data before the current bit was sampled
  assign advance = launch & (sampled_r | sample) & xtx_r;

  // ----------------------------------------------------------------
  // transfer start
  // ----------------------------------------------------------------
  logic tx_avail;
  logic rx_want;
  logic go_tx;
  logic go_rx;
  logic start;
  assign tx_avail = rd_s.valid;
  assign rx_want = seq_rx ? !rend_r : (unit_rx & unit_pend_r & !rend_r & !rfr_r);
  assign go_tx = tx_avail & (!align | rx_want);
  assign go_rx = rx_want & (!align | tx_avail);
  assign start = !running & clk_en & div_ok & (go_tx | go_rx);
  assign rd_s.ready = start & go_tx;
  assign wr_s.valid = bus_wr & hit_td;
  assign wr_s.data = bus_wdata;

  // ----------------------------------------------------------------
  // serial data paths
  // ----------------------------------------------------------------
  logic [3:0] first_pos;
  logic [3:0] tx_pos;
  logic [3:0] samp_pos;
  logic [4:0] tx_next_k;
  logic rx_bit;
  logic crc_vld;
  logic crc_bit;
  logic sdo_nxt;
  logic [15:0] crc_val;
  assign tx_next_k = bit_tx_r + 5'h01;
  assign first_pos = bit_pos(5'h00, msb_first, u16);
  assign tx_pos = bit_pos(tx_next_k, msb_first, u16);
  assign samp_pos = bit_pos(bit_rx_r, msb_first, u16);
  assign rx_bit = (loop_en ? sdo_r : serial_data_in_pin) ^ rx_inv;
  assign crc_vld = sample & (crc_rx ? xrx_r : xtx_r);
  assign crc_bit = crc_rx ? rx_bit : txsh_r[samp_pos];
  assign sdo_nxt = start ? (go_tx ? rd_s.data[first_pos] ^ tx_inv : idle_lvl)
                 : done ? idle_lvl
                 : advance ? txsh_r[tx_pos] ^ tx_inv
                 : running ? sdo_r : idle_lvl;

  crc_engine u_crc (
    .clk(ref_clk),
    .rst_n(rst_n),
    .clear_n(crc_run),
    .poly16(crc16),
    .bit_vld(crc_vld),
    .bit_in(crc_bit),
    .crc(crc_val)
  );

  // ----------------------------------------------------------------
  // status and interrupt terms
  // ----------------------------------------------------------------
  logic [3:0] cond;
  logic [3:0] rise_c;
  logic [3:0] oneshot;
  logic [3:0] is_clr;
  logic [3:0] is_nxt;
  logic [3:0] irq_req;
  logic rd_rd;
  logic unit_set;
  assign cond = {!tx_full_r, rend_r, !rd_s.valid, rfr_r};
  assign rise_c = cond & ~cond_d_r;
  assign oneshot = {2'b00, dmaw_en, dmar_en};
  assign is_clr = (bus_wr & hit_is) ? (bus_wdata[3:0] & we_r[3:0]) : 4'h0;
  assign is_nxt = (is_r & ~is_clr) | (rise_c & ~oneshot);
  assign irq_req = is_r & ie_r[3:0];
  assign rd_rd = bus_rd & hit_rd;
  assign unit_set = (bus_wr & hit_ct & bus_wdata[CT_ONE] & !ctrl_r[CT_ONE])
                  | (rd_rd & unit_rx);

  // ----------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  assign rd_mux = hit_md ? mode_r
                : hit_ct ? ctrl_r
                : hit_st ? {12'h000, cond}
                : hit_cr ? crc_val
                : hit_is ? {12'h000, is_r}
                : hit_we ? we_r
                : hit_ie ? ie_r
                : hit_ir ? {12'h000, irq_req}
                : hit_rd ? rdbuf_r
                : hit_ts ? txsh_r
                : hit_rs ? rxsh_r
                : 16'h0000;

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r <= MODE_RST;
      ctrl_r <= CTRL_RST;
      we_r <= 16'h0000;
      ie_r <= 16'h0000;
    end else if (bus_wr) begin
      if (hit_md) mode_r <= bus_wdata & MODE_WMASK;
      if (hit_ct) ctrl_r <= bus_wdata & CTRL_WMASK;
      if (hit_we) we_r <= bus_wdata & IRQ_WMASK;
      if (hit_ie) ie_r <= bus_wdata & IRQ_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // divider and clock pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt_r <= 5'h00;
      sclk_r <= 1'b0;
    end else begin
      div_cnt_r <= (tick || !clk_en || !div_ok) ? 5'h00 : div_cnt_r + 5'h01;
      if (toggle) sclk_r <= !sclk_r;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      tick_cnt_r <= 6'h00;
      bit_tx_r <= 5'h00;
      bit_rx_r <= 5'h00;
      sampled_r <= 1'b0;
      xtx_r <= 1'b0;
      xrx_r <= 1'b0;
      sdo_r <= 1'b1;
    end else begin
      sdo_r <= sdo_nxt;
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_RUN;
            tick_cnt_r <= 6'h00;
            bit_tx_r <= 5'h00;
            bit_rx_r <= 5'h00;
            sampled_r <= 1'b0;
            xtx_r <= go_tx;
            xrx_r <= go_rx;
          end
        end
        ST_RUN: begin
          if (live) tick_cnt_r <= tick_cnt_r + 6'h01;
          if (sample) bit_rx_r <= bit_rx_r + 5'h01;
          if (advance) bit_tx_r <= tx_next_k;
          if (advance) sampled_r <= 1'b0;
          else if (sample) sampled_r <= 1'b1;
          if (done) state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift and buffer registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txsh_r <= 16'h0000;
      rxsh_r <= 16'h0000;
      rdbuf_r <= 16'h0000;
      tx_full_r <= 1'b0;
      rend_r <= 1'b0;
      rfr_r <= 1'b0;
    end else begin
      if (rd_s.ready) txsh_r <= rd_s.data;
      if (rd_s.ready) tx_full_r <= 1'b1;
      else if (done) tx_full_r <= 1'b0;
      if (start && go_rx) rxsh_r <= 16'h0000;
      else if (sample && xrx_r) rxsh_r[samp_pos] <= rx_bit;
      if (done && xrx_r) rend_r <= 1'b1;
      else if (rend_r && !rfr_r) rend_r <= 1'b0;
      if (rend_r && !rfr_r) rdbuf_r <= rxsh_r;
      if (rend_r && !rfr_r) rfr_r <= 1'b1;
      else if (rd_rd) rfr_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unit_pend_r <= 1'b0;
    end else if (unit_set) begin
      unit_pend_r <= 1'b1;
    end else if (start && go_rx && !seq_rx) begin
      unit_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt, dma and bus outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      is_r <= 4'h0;
      cond_d_r <= COND_RST;
      irq_r <= 1'b0;
      dmat_r <= 1'b0;
      dmar_r <= 1'b0;
      rdata_r <= 16'h0000;
      space_r <= 1'b0;
    end else begin
      is_r <= is_nxt;
      cond_d_r <= cond;
      irq_r <= |irq_req;
      dmat_r <= rise_c[1] & dmaw_en;
      dmar_r <= rise_c[0] & dmar_en;
      rdata_r <= bus_rd ? rd_mux : 16'h0000;
      space_r <= wr_s.ready;
    end
  end

  assign bus_rdata = rdata_r;
  assign tx_space = space_r;
  assign serial_data_out_pin = sdo_r;
  assign serial_clock_pin = sclk_r;
  assign combined_port_irq = irq_r;
  assign dma_tx_req = dmat_r;
  assign dma_rx_req = dmar_r;
endmodule
`default_nettype wire

/* fast_serial_port_assertions.sv */
// concurrent checks on the fast serial port pins
`timescale 1ns/1ps
`default_nettype none
module fast_serial_port_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic tx_space,
  input wire logic serial_data_out_pin,
  input wire logic serial_clock_pin,
  input wire logic combined_port_irq,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_release;
    $rose(rst_n);
  endsequence
  sequence s_recent_write;
    $past(bus_wr) || $past(bus_wr, 2) || $past(bus_wr, 3);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_clock_held_off: assert property (s_release |-> !serial_clock_pin [*2])
    else $error("shift clock active right after reset");
  chk_idle_out_high: assert property (s_release |-> serial_data_out_pin [*2])
    else $error("data out not at idle level after reset");
  chk_irq_quiet_reset: assert property (s_release |-> !combined_port_irq [*2])
    else $error("interrupt raised right after reset");
  chk_dma_tx_pulse: assert property (dma_tx_req |=> !dma_tx_req)
    else $error("tx dma request longer than one cycle");
  chk_dma_rx_pulse: assert property (dma_rx_req |=> !dma_rx_req)
    else $error("rx dma request longer than one cycle");
  chk_dma_tx_space: assert property (dma_tx_req |-> tx_space)
    else $error("tx dma request while buffer full");
  chk_irq_clear_write: assert property ($fell(combined_port_irq) |-> s_recent_write)
    else $error("interrupt dropped without a register write");
  chk_read_data_quiet: assert property (!bus_rd |=> bus_rdata == 16'h0000)
    else $error("read data not zero outside a read");
endmodule
bind fast_serial_port fast_serial_port_assertions chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .tx_space(tx_space),
  .serial_data_out_pin(serial_data_out_pin), .serial_clock_pin(serial_clock_pin),
  .combined_port_irq(combined_port_irq), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
`default_nettype wire

/* serial_slave_model.sv */
// behavioural slave on the serial link
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model #(
  parameter logic [15:0] PATTERN = 16'h5a3c
) (
  input wire logic sclk,
  input wire logic sdo,
  output logic sdi,
  output logic [15:0] rx_word
);
  logic [3:0] cnt_r = 4'h0;
  logic [15:0] cap_r = 16'h0000;
  logic out_r = PATTERN[15];
  // samples on the rising clock edge
  always @(posedge sclk) begin
    cap_r <= {cap_r[14:0], sdo};
    cnt_r <= cnt_r + 4'h1;
  end
  // next bit launched on falling edge, after the master sampled the last
  always @(negedge sclk) begin
    out_r <= PATTERN[4'hf - cnt_r];
  end
  assign sdi = out_r;
  assign rx_word = cap_r;
endmodule
`default_nettype wire

/* fast_serial_port_tb.sv */
// self-checking bench for the fast serial port
`timescale 1ns/1ps
`default_nettype none
module fast_serial_port_tb;
  import fast_serial_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] bus_addr = 12'h000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bus_rdata;
  logic tx_space, sdi, sdo, sclk, sclk_q, irq, dma_tx, dma_rx;
  logic [15:0] slave_word;
  logic [15:0] v;
  int n_fail = 0;
  int checks_done = 0;
  int n_dtx = 0;
  int n_drx = 0;
  int n_tog = 0;
  int hi_run = 0;
  int hi_last = 0;
  int d0;
  int d1;
  fast_serial_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .tx_space(tx_space),
    .serial_data_in_pin(sdi), .serial_data_out_pin(sdo), .serial_clock_pin(sclk),
    .combined_port_irq(irq), .dma_tx_req(dma_tx), .dma_rx_req(dma_rx));
  serial_slave_model #(.PATTERN(16'h5a3c)) peer (.sclk(sclk), .sdo(sdo), .sdi(sdi),
    .rx_word(slave_word));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // pin monitors
  // ----------------------------------------
  always @(posedge ref_clk) begin
    sclk_q <= sclk;
    if (dma_tx === 1'b1) n_dtx <= n_dtx + 1;
    if (dma_rx === 1'b1) n_drx <= n_drx + 1;
    if (sclk === 1'b1 && sclk_q === 1'b0) n_tog <= n_tog + 1;
    if (sclk === 1'b1) hi_run <= hi_run + 1;
    else if (hi_run != 0) begin
      hi_last <= hi_run;
      hi_run <= 0;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_stat(input logic [15:0] m);
    logic [15:0] s;
    for (int i = 0; i < 3000; i++) begin
      rd(OFS_STAT, s);
      if ((s & m) === m) return;
    end
    n_fail++;
    $display("MISMATCH t=%0t status wait expired", $time);
    end_sim();
  endtask
  // reference crc, bits in wire order from a zero start
  function automatic logic [15:0] crc_ref(input logic [15:0] w, input int n, input logic p16);
    logic [15:0] c;
    logic fb;
    c = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      fb = (p16 ? c[15] : c[6]) ^ w[i];
      c = {c[14:0], 1'b0};
      if (fb) c = c ^ (p16 ? 16'h1021 : 16'h0009);
    end
    return p16 ? c : {9'h000, c[6:0]};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(OFS_MODE, 16'h6000);
    rdc(OFS_CTRL, 16'h0040);
    rdc(OFS_STAT, 16'h000a);
    rdc(12'hc18, 16'h0000);
    wr(OFS_MODE, 16'hffbf);
    rdc(OFS_MODE, 16'hef07);
    wr(OFS_CRC, 16'hffff);
    rdc(OFS_CRC, 16'h0000);
    // full duplex 16-bit unit with the external slave
    wr(OFS_MODE, 16'h6401);
    wr(OFS_MODE, 16'h6441);
    wr(OFS_CTRL, 16'h8065);
    wr(OFS_CTRL, 16'ha065);
    wr(OFS_TXWB, 16'h81c3);
    wait_stat(16'h0001);
    chk(slave_word, 16'h81c3);
    chk({15'h0000, sdo}, 16'h0001);
    rdc(OFS_RXRB, 16'h5a3c);
    rdc(OFS_CRC, crc_ref(16'h81c3, 16, 1'b1));
    // append the crc as a further unit
    wr(OFS_TXWB, crc_ref(16'h81c3, 16, 1'b1));
    wait_stat(16'h0001);
    chk(slave_word, crc_ref(16'h81c3, 16, 1'b1));
    rdc(OFS_RXRB, 16'h5a3c);
    // lsb first bytes, fill the buffer until it refuses
    wr(OFS_MODE, 16'h6401);
    wr(OFS_MODE, 16'h2001);
    wr(OFS_CTRL, 16'h0240);
    for (int i = 0; i < 17; i++) wr(OFS_TXWB, 16'h0010 + 16'(i));
    chk({15'h0000, tx_space}, 16'h0000);
    rdc(OFS_STAT, 16'h0008);
    d0 = n_dtx;
    wr(OFS_MODE, 16'h2041);
    repeat (2) wait_stat(16'h000a);
    chk(slave_word, 16'h78f8);
    chk(16'(n_dtx - d0), 16'h0001);
    // loopback with both inversions, crc-7 on receive data
    wr(OFS_MODE, 16'h2001);
    wr(OFS_MODE, 16'he703);
    wr(OFS_MODE, 16'he743);
    wr(OFS_CTRL, 16'h4145);
    wr(OFS_CTRL, 16'h6145);
    d0 = n_tog;
    repeat (40) @(posedge ref_clk);
    chk({15'h0000, (n_tog - d0) >= 4}, 16'h0001);
    chk(16'(hi_last), 16'h0004);
    wr(OFS_WE, 16'h000f);
    // drop status left from earlier units
    wr(OFS_IS, 16'h000f);
    wr(OFS_IE, 16'h0008);
    d1 = n_drx;
    wr(OFS_TXWB, 16'h00a5);
    wait_stat(16'h0001);
    rdc(OFS_RXRB, 16'h00a5);
    chk({15'h0000, irq}, 16'h0001);
    chk(16'(n_drx - d1), 16'h0001);
    rdc(OFS_CRC, crc_ref(16'h00a5, 8, 1'b0));
    rdc(OFS_IR, 16'h0008);
    wr(OFS_IS, 16'h0008);
    rd(OFS_IS, v);
    chk(v & 16'h0008, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    // sequential reception, idle low inverted arrives as ones
    wr(OFS_MODE, 16'hc743);
    wr(OFS_CTRL, 16'h0043);
    wait_stat(16'h0005);
    rdc(OFS_STAT, 16'h000f);
    rdc(OFS_RXRB, 16'h00ff);
    end_sim();
  end
endmodule
`default_nettype wire
